// ==== common/i2c_master_pkg.sv ====
// Constants, register map and types of the single-master I2C controller.
package i2c_master_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses, one 32-bit word each)
    // ------------------------------------------------------------------
    localparam int ADDR_W = 5;
    localparam logic [4:0] ADDR_DATA = 5'h00;
    localparam logic [4:0] ADDR_CTRL = 5'h04;
    localparam logic [4:0] ADDR_STAT = 5'h08;
    localparam logic [4:0] ADDR_IRQ_STAT = 5'h0C;
    localparam logic [4:0] ADDR_IRQ_MASK = 5'h10;
    localparam logic [4:0] ADDR_SLAVE = 5'h14;
    localparam int BUS_W = 32;
    localparam int BYTE_W = 8;
    localparam int SLAVE_W = 10;

    // ------------------------------------------------------------------
    // Interrupt bit positions
    // ------------------------------------------------------------------
    localparam int IRQ_W = 3;
    localparam int IRQ_NACK = 0;
    localparam int IRQ_RX = 1;
    localparam int IRQ_TX = 2;

    // ------------------------------------------------------------------
    // Protocol constants
    // ------------------------------------------------------------------
    localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [1:0] STEP_FIRST = 2'h0;
    localparam logic [1:0] STEP_SECOND = 2'h1;
    localparam logic [1:0] STEP_READ_HDR = 2'h2;
    localparam logic [1:0] PH_SAMPLE = 2'h2;
    localparam logic [1:0] PH_LAST = 2'h3;

    // ------------------------------------------------------------------
    // Timing: 100 kHz bit time split into four quarter phases
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int BIT_TIME_NS = 10000;
    localparam int QUARTER_CYCLES_DEFAULT =
        (BIT_TIME_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
    localparam int DIV_W = 16;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic ten_bit;
        logic dir_read;
        logic transmit_irq_enable;
        logic nak_last;
        logic stop_req;
        logic start_req;
    } ctrl_t;
    localparam int CTRL_W = 6;
    localparam ctrl_t CTRL_RESET = ctrl_t'(6'h00);

    typedef struct packed {
        logic tx_full;
        logic rx_data_full_flag;
        logic busy;
        logic ack;
    } status_t;
    localparam int STAT_W = 4;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_START = 3'b001,
        ST_SEND = 3'b010,
        ST_RECV = 3'b011,
        ST_HOLD = 3'b100,
        ST_RSTART = 3'b101,
        ST_STOP = 3'b110
    } state_t;

endpackage

// ==== sim/i2c_master_assertions.sv ====
// Port-level checks of the I2C master controller.
`timescale 1ns/100ps
module i2c_master_assertions
    import i2c_master_pkg::*;
#(
    parameter int QUARTER_CYCLES = QUARTER_CYCLES_DEFAULT
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [BUS_W-1:0] avs_writedata,
    input wire logic [BUS_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic irq,
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    logic [31:0] lo_cnt;
    logic [31:0] hi_cnt;
    logic [31:0] next_lo_cnt;
    logic [31:0] next_hi_cnt;
    // Phase lengths; a clipped quarter would break slow slaves.
    always_comb begin
        next_lo_cnt = scl_oe ? lo_cnt + 32'h1 : 32'h0;
        next_hi_cnt = scl_oe ? 32'h0 : hi_cnt + 32'h1;
    end
    always_ff @(posedge clk_sys) begin
        lo_cnt <= reset ? 32'h0 : next_lo_cnt;
        hi_cnt <= reset ? 32'h0 : next_hi_cnt;
    end
    a_wait_one: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest did not drop");
    a_wait_pulse: assert property (
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_wait_idle: assert property (
        !(avs_read || avs_write) |=> avs_waitrequest)
        else $error("waitrequest low without request");
    a_unmapped_zero: assert property (
        avs_read && !avs_waitrequest && avs_address > ADDR_SLAVE
        |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
    a_mask_quiet: assert property (
        avs_write && !avs_waitrequest && avs_address == ADDR_IRQ_MASK
        && avs_writedata[IRQ_W-1:0] == 3'h0 |-> ##[1:2] !irq)
        else $error("irq high with all masked");
    a_open_drain: assert property (
        scl_out == 1'b0 && sda_out == 1'b0)
        else $error("pin driven high");
    a_scl_low_len: assert property (
        $fell(scl_oe) |-> lo_cnt >= QUARTER_CYCLES)
        else $error("clock low phase too short");
    a_stop_bus: assert property (
        $fell(sda_oe) && !scl_oe && hi_cnt > 32'h1
        |=> (!scl_oe && !sda_oe) [*8]) else $error("bus not free after stop");
    c_read: cover property (avs_read && !avs_waitrequest);
    c_irq: cover property ($rose(irq));
    c_stop: cover property ($fell(sda_oe) && !scl_oe && hi_cnt > 32'h1);
endmodule
bind i2c_master i2c_master_assertions #(.QUARTER_CYCLES(QUARTER_CYCLES))
    i_chk (.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq(irq), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));

// ==== sim/i2c_slave_model.sv ====
// Behavioural I2C slave: acks on request, answers reads, logs bytes.
`timescale 1ns/100ps
module i2c_slave_model (
    input wire logic scl,
    input wire logic sda,
    input wire logic ack_en,
    input wire logic [7:0] rd_byte,
    output logic sda_pull,
    output logic mack
);
    logic [7:0] log_mem [0:7];
    logic [7:0] sh = 8'h00;
    logic reading = 1'b0;
    int bitn = 0;
    int idx = 0;
    int nlog = 0;
    initial begin
        sda_pull = 1'b0;
        mack = 1'b0;
    end
    // A start or repeated start restarts the byte framing.
    always @(negedge sda) begin
        if (scl) begin
            bitn = 0;
            idx = 0;
            reading = 1'b0;
        end
    end
    // A stop ends any read, so the line is free for the next frame.
    always @(posedge sda) begin
        if (scl) begin
            reading = 1'b0;
            sda_pull = 1'b0;
        end
    end
    // Sample in the high phase; the ninth bit of a read is the master's.
    always @(posedge scl) begin
        if (bitn < 8)
            sh = {sh[6:0], sda};
        else if (reading)
            mack = ~sda;
        bitn = bitn + 1;
    end
    // Change the line only while the clock is low.
    always @(negedge scl) begin
        if (bitn == 9) begin
            bitn = 0;
            if (reading && !mack)
                reading = 1'b0;
            if (idx == 0)
                reading = sh[0] & ack_en;
            idx = idx + 1;
            sda_pull = reading & ~rd_byte[7];
        end else if (reading) begin
            sda_pull = (bitn < 8) ? ~rd_byte[7 - bitn] : 1'b0;
        end else if (bitn == 8) begin
            log_mem[nlog % 8] = sh;
            nlog = nlog + 1;
            sda_pull = ack_en;
        end
    end
endmodule

// ==== sim/tb_top.sv ====
// Self-checking bench: register bus, interrupts and read transfers.
`timescale 1ns/100ps
module tb_top
    import i2c_master_pkg::*;
;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [ADDR_W-1:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [BUS_W-1:0] avs_writedata = 32'h0;
    logic [BUS_W-1:0] avs_readdata;
    logic avs_waitrequest;
    logic irq;
    logic scl_out;
    logic scl_oe;
    logic sda_out;
    logic sda_oe;
    logic sda_pull;
    logic mack;
    logic ack_en = 1'b1;
    logic [7:0] rd_byte = 8'hA5;
    logic [BUS_W-1:0] rv;
    int n_errors = 0;
    int samples_checked = 0;
    // Open-drain wires with pull-ups; either party may pull SDA low, only the master SCL.
    wire scl_w = scl_oe ? scl_out : 1'b1;
    wire sda_w = (sda_oe ? sda_out : 1'b1) & ~sda_pull;
    // A short quarter keeps the run brief; the slave reacts on edges.
    i2c_master #(.QUARTER_CYCLES(8)) i_dut (
        .clk_sys(clk_sys), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq), .scl_in(scl_w),
        .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w),
        .sda_out(sda_out), .sda_oe(sda_oe));
    i2c_slave_model i_slave (.scl(scl_w), .sda(sda_w), .ack_en(ack_en),
        .rd_byte(rd_byte), .sda_pull(sda_pull), .mack(mack));
    initial begin
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic finish_test;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One bus cycle; held until waitrequest is sampled low.
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        q = avs_readdata;
        if (avs_waitrequest !== 1'b0) begin
            check("bus answer", 32'h0, 32'h1);
            finish_test();
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, q);
    endtask
    task automatic check_reg(input string what, input logic [ADDR_W-1:0] a,
        input logic [31:0] exp);
        rd(a, rv);
        check(what, exp, rv);
    endtask
    // Polls a register bit; a bounded count stands in for a hang.
    task automatic wait_bit(input logic [ADDR_W-1:0] a, input int b,
        input logic v);
        int n;
        n = 0;
        rv = {BUS_W{~v}};
        while (rv[b] !== v && n < 1000) begin
            rd(a, rv);
            n++;
        end
        if (rv[b] !== v) begin
            check("poll", 32'h0, 32'h1);
            finish_test();
        end
    endtask
    task automatic wait_irq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 5000) begin
            @(posedge clk_sys);
            n++;
        end
        if (irq !== 1'b1) begin
            check("irq wait", 32'h0, 32'h1);
            finish_test();
        end
    endtask
    task automatic test_regs;
        check_reg("ctrl", ADDR_CTRL, 32'h0);
        check_reg("irq stat", ADDR_IRQ_STAT, 32'h0);
        wr(ADDR_STAT, 32'h0000000F);
        check_reg("stat", ADDR_STAT, 32'h0);
        wr(5'h18, 32'hFFFFFFFF);
        check_reg("unmapped", 5'h18, 32'h0);
        wr(ADDR_IRQ_MASK, 32'hFFFFFFFF);
        check_reg("mask", ADDR_IRQ_MASK, 32'h7);
    endtask
    task automatic test_addr_nack;
        ack_en <= 1'b0;
        wr(ADDR_IRQ_MASK, 32'h0);
        wr(ADDR_SLAVE, 32'h2A);
        wr(ADDR_CTRL, 32'h19);
        wait_bit(ADDR_IRQ_STAT, IRQ_NACK, 1'b1);
        check("header", 32'h55, i_slave.log_mem[0]);
        check_reg("ack clear", ADDR_STAT, 32'h2);
        check("masked irq", 32'h0, irq);
        wr(ADDR_IRQ_MASK, 32'h7);
        wait_irq();
        wr(ADDR_CTRL, 32'h12);
        wait_bit(ADDR_STAT, 1, 1'b0);
        check_reg("nack cleared", ADDR_IRQ_STAT, 32'h0);
        check_reg("stop cleared", ADDR_CTRL, 32'h10);
        check("irq low", 32'h0, irq);
        ack_en <= 1'b1;
    endtask
    task automatic test_read7;
        wr(ADDR_SLAVE, 32'h2A);
        wr(ADDR_CTRL, 32'h11);
        wait_irq();
        rd_byte <= 8'h96;
        check_reg("rx irq", ADDR_IRQ_STAT, 32'h2);
        rd(ADDR_STAT, rv);
        check("ack rx full", 32'h5, rv & 32'h5);
        check("header", 32'h55, i_slave.log_mem[1]);
        check("master ack", 32'h1, mack);
        wr(ADDR_CTRL, 32'h14);
        wr(ADDR_IRQ_STAT, 32'h2);
        check_reg("byte 1", ADDR_DATA, 32'hA5);
        rd(ADDR_STAT, rv);
        check("rx cleared", 32'h0, rv[2]);
        wait_irq();
        check_reg("last irq", ADDR_IRQ_STAT, 32'h3);
        check("master nack", 32'h0, mack);
        wr(ADDR_CTRL, 32'h16);
        wait_bit(ADDR_STAT, 1, 1'b0);
        check_reg("byte 2", ADDR_DATA, 32'h96);
        check_reg("nack gone", ADDR_IRQ_STAT, 32'h2);
        wr(ADDR_IRQ_STAT, 32'h7);
    endtask
    task automatic test_read10;
        rd_byte <= 8'h5A;
        wr(ADDR_SLAVE, 32'h2B5);
        wr(ADDR_CTRL, 32'h35);
        wait_irq();
        check("hdr write", 32'hF4, i_slave.log_mem[2]);
        check("low byte", 32'hB5, i_slave.log_mem[3]);
        check("hdr read", 32'hF5, i_slave.log_mem[4]);
        check_reg("nack irq", ADDR_IRQ_STAT, 32'h3);
        wr(ADDR_CTRL, 32'h36);
        wait_bit(ADDR_STAT, 1, 1'b0);
        check_reg("byte", ADDR_DATA, 32'h5A);
    endtask
    initial begin
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        test_regs();
        test_addr_nack();
        test_read7();
        test_read10();
        finish_test();
    end
endmodule

// ==== verilog/i2c_master.sv ====
// Single-master I2C controller with an Avalon-MM register slave.
`timescale 1ns/100ps
module i2c_master
    import i2c_master_pkg::*;
#(
    parameter int QUARTER_CYCLES = QUARTER_CYCLES_DEFAULT
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [BUS_W-1:0] avs_writedata,
    output logic [BUS_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe
);

    // The divider must reach at least one cycle and fit its counter.
    if (QUARTER_CYCLES < 1 || QUARTER_CYCLES >= (1 << DIV_W)) begin
        $error("QUARTER_CYCLES out of range");
    end

    localparam logic [DIV_W-1:0] DIV_RELOAD = DIV_W'(QUARTER_CYCLES - 1);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [2:0] scl_sync, next_scl_sync;
    logic [2:0] sda_sync, next_sda_sync;
    logic scl_level, next_scl_level;
    logic sda_level, next_sda_level;

    // A level is only accepted once the second and third stages agree.
    always_comb begin
        next_scl_sync = {scl_sync[1:0], scl_in};
        next_sda_sync = {sda_sync[1:0], sda_in};
        next_scl_level = scl_level;
        next_sda_level = sda_level;
        if (scl_sync[2] == scl_sync[1]) begin
            next_scl_level = scl_sync[2];
        end
        if (sda_sync[2] == sda_sync[1]) begin
            next_sda_level = sda_sync[2];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
            scl_level <= 1'b1;
            sda_level <= 1'b1;
        end else begin
            scl_sync <= next_scl_sync;
            sda_sync <= next_sda_sync;
            scl_level <= next_scl_level;
            sda_level <= next_sda_level;
        end
    end

    // ------------------------------------------------------------------
    // State of registers and bit engine
    // ------------------------------------------------------------------
    ctrl_t ctrl, next_ctrl;
    logic [SLAVE_W-1:0] slave_addr, next_slave_addr;
    logic [BYTE_W-1:0] tx_data, next_tx_data;
    logic [BYTE_W-1:0] rx_data, next_rx_data;
    status_t stat, next_stat;
    logic [IRQ_W-1:0] irq_status, next_irq_status;
    logic [IRQ_W-1:0] irq_mask, next_irq_mask;
    logic [IRQ_W-1:0] irq_set;
    logic nack_done;
    logic [BUS_W-1:0] next_readdata;
    logic next_waitrequest, next_irq;
    state_t state, next_state;
    logic [1:0] phase, next_phase;
    logic [3:0] bitcnt, next_bitcnt;
    logic [BYTE_W-1:0] shreg, next_shreg;
    logic [1:0] step, next_step;
    logic in_data, next_in_data;
    logic [DIV_W-1:0] div, next_div;
    logic next_scl_oe, next_sda_oe;
    logic tick, bit_end, bus_req, take_wr, take_rd;

    assign tick = (div == '0);
    assign bus_req = avs_read | avs_write;
    assign take_wr = avs_write & ~avs_waitrequest;
    assign take_rd = avs_read & ~avs_waitrequest;
    // The high half of a bit is held until the wire really reads high.
    assign bit_end = tick & (phase == PH_LAST);

    // ------------------------------------------------------------------
    // Avalon-MM slave and interrupt logic
    // ------------------------------------------------------------------
    // Every access waits one cycle, so read data is registered cleanly.
    always_comb begin
        next_waitrequest = ~(bus_req & avs_waitrequest);
        next_readdata = avs_readdata;
        if (avs_read & avs_waitrequest) begin
            case (avs_address)
                ADDR_DATA: next_readdata = BUS_W'(rx_data);
                ADDR_CTRL: next_readdata = BUS_W'(ctrl);
                ADDR_STAT: next_readdata = BUS_W'(stat);
                ADDR_IRQ_STAT: next_readdata = BUS_W'(irq_status);
                ADDR_IRQ_MASK: next_readdata = BUS_W'(irq_mask);
                ADDR_SLAVE: next_readdata = BUS_W'(slave_addr);
                default: next_readdata = '0;
            endcase
        end
        next_irq_mask = irq_mask;
        next_slave_addr = slave_addr;
        next_tx_data = tx_data;
        if (take_wr && avs_address == ADDR_IRQ_MASK) begin
            next_irq_mask = avs_writedata[IRQ_W-1:0];
        end
        if (take_wr && avs_address == ADDR_SLAVE) begin
            next_slave_addr = avs_writedata[SLAVE_W-1:0];
        end
        if (take_wr && avs_address == ADDR_DATA) begin
            next_tx_data = avs_writedata[BYTE_W-1:0];
        end
        // Write one to clear; a new event in the same cycle still sets.
        next_irq_status = irq_status;
        if (take_wr && avs_address == ADDR_IRQ_STAT) begin
            next_irq_status = irq_status & ~avs_writedata[IRQ_W-1:0];
        end
        if (nack_done) begin
            next_irq_status[IRQ_NACK] = 1'b0;
        end
        next_irq_status = next_irq_status | irq_set;
        next_irq = |(next_irq_status & next_irq_mask);
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            avs_readdata <= '0;
            avs_waitrequest <= 1'b1;
            irq_status <= '0;
            irq_mask <= '0;
            slave_addr <= '0;
            tx_data <= '0;
            irq <= 1'b0;
        end else begin
            avs_readdata <= next_readdata;
            avs_waitrequest <= next_waitrequest;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            slave_addr <= next_slave_addr;
            tx_data <= next_tx_data;
            irq <= next_irq;
        end
    end

    // ------------------------------------------------------------------
    // Master sequencer; there is no slave or arbitration path at all
    // ------------------------------------------------------------------
    // One process keeps control bits and the engine consistent, since the
    // engine clears bits that software also writes.
    always_comb begin
        next_ctrl = ctrl;
        next_stat = stat;
        next_rx_data = rx_data;
        next_state = state;
        next_phase = phase;
        next_bitcnt = bitcnt;
        next_shreg = shreg;
        next_step = step;
        next_in_data = in_data;
        next_div = tick ? DIV_RELOAD : div - 1'b1;
        irq_set = '0;
        nack_done = 1'b0;
        next_scl_oe = 1'b0;
        next_sda_oe = 1'b0;
        // Hold the quarter counter while a slave stretches SCL.
        if (tick && !(phase == PH_SAMPLE && !scl_level)) begin
            next_phase = phase + 1'b1;
        end else if (tick) begin
            next_div = '0;
        end
        case (state)
            ST_IDLE: begin
                // Reloading here gives the first quarter of a frame full length.
                next_div = DIV_RELOAD;
                next_phase = '0;
                next_ctrl.stop_req = 1'b0;
                if (ctrl.start_req) begin
                    next_state = ST_START;
                    next_stat.busy = 1'b1;
                    next_stat.ack = 1'b0;
                end
            end
            ST_START, ST_RSTART: begin
                next_scl_oe = (phase == '0) || (phase == PH_LAST);
                next_sda_oe = (phase >= PH_SAMPLE);
                if (bit_end) begin
                    next_state = ST_SEND;
                    next_bitcnt = '0;
                    next_in_data = 1'b0;
                    next_ctrl.start_req = 1'b0;
                    if (state == ST_RSTART) begin
                        next_step = STEP_READ_HDR;
                        next_shreg = {TEN_BIT_PREFIX, slave_addr[9:8],
                                      1'b1};
                    end else if (ctrl.ten_bit) begin
                        next_step = STEP_FIRST;
                        next_shreg = {TEN_BIT_PREFIX, slave_addr[9:8],
                                      1'b0};
                    end else begin
                        next_step = STEP_FIRST;
                        next_shreg = {slave_addr[6:0],
                                      ctrl.dir_read};
                    end
                end
            end
            ST_SEND: begin
                next_scl_oe = (phase < PH_SAMPLE);
                // SDA moves one quarter after SCL falls, never on that edge.
                next_sda_oe = (phase == '0) ? sda_oe :
                              ((bitcnt != ACK_BIT) && !shreg[BYTE_W-1]);
                if (tick && phase == PH_SAMPLE && scl_level &&
                    bitcnt == ACK_BIT) begin
                    next_stat.ack = ~sda_level;
                end
                if (bit_end && bitcnt != ACK_BIT) begin
                    next_shreg = {shreg[BYTE_W-2:0], 1'b0};
                    next_bitcnt = bitcnt + 1'b1;
                end else if (bit_end) begin
                    next_state = ST_HOLD;
                    if (!stat.ack) begin
                        irq_set[IRQ_NACK] = 1'b1;
                    end else if (!in_data && ctrl.ten_bit &&
                                 step == STEP_FIRST) begin
                        next_state = ST_SEND;
                        next_step = STEP_SECOND;
                        next_bitcnt = '0;
                        next_shreg = slave_addr[BYTE_W-1:0];
                    end else if (!in_data && step == STEP_SECOND &&
                                 ctrl.dir_read) begin
                        next_state = ST_RSTART;
                        next_phase = '0;
                    end else begin
                        next_in_data = 1'b1;
                    end
                end
            end
            ST_RECV: begin
                next_scl_oe = (phase < PH_SAMPLE);
                next_sda_oe = (phase == '0) ? sda_oe :
                              ((bitcnt == ACK_BIT) && !ctrl.nak_last);
                if (tick && phase == PH_SAMPLE && scl_level &&
                    bitcnt != ACK_BIT) begin
                    next_shreg = {shreg[BYTE_W-2:0], sda_level};
                end
                if (bit_end && bitcnt != ACK_BIT) begin
                    next_bitcnt = bitcnt + 1'b1;
                end else if (bit_end) begin
                    next_state = ST_HOLD;
                    next_rx_data = shreg;
                    next_stat.rx_data_full_flag = 1'b1;
                    irq_set[IRQ_RX] = 1'b1;
                    if (ctrl.nak_last) begin
                        irq_set[IRQ_NACK] = 1'b1;
                        next_in_data = 1'b0;
                    end
                end
            end
            ST_HOLD: begin
                // SCL is held low, so the slave waits while software acts.
                // SDA keeps its level, so it never changes as SCL falls.
                next_scl_oe = 1'b1;
                next_sda_oe = sda_oe;
                next_phase = '0;
                next_bitcnt = '0;
                if (in_data && !ctrl.dir_read && !stat.tx_full &&
                    ctrl.transmit_irq_enable) begin
                    irq_set[IRQ_TX] = 1'b1;
                end
                if (ctrl.stop_req) begin
                    next_state = ST_STOP;
                end else if (ctrl.start_req) begin
                    next_state = ST_RSTART;
                end else if (in_data && stat.ack && ctrl.dir_read &&
                             !stat.rx_data_full_flag) begin
                    next_state = ST_RECV;
                end else if (in_data && stat.ack && !ctrl.dir_read &&
                             stat.tx_full) begin
                    next_state = ST_SEND;
                    next_shreg = tx_data;
                    next_stat.tx_full = 1'b0;
                end
            end
            ST_STOP: begin
                next_scl_oe = (phase == '0);
                next_sda_oe = (phase < PH_SAMPLE);
                if (bit_end) begin
                    next_state = ST_IDLE;
                    next_ctrl.stop_req = 1'b0;
                    nack_done = 1'b1;
                    next_stat.busy = 1'b0;
                    next_in_data = 1'b0;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        // Software writes come last, so a set in the same cycle wins.
        if (take_wr && avs_address == ADDR_CTRL) begin
            next_ctrl = ctrl_t'(avs_writedata[CTRL_W-1:0]);
        end
        if (take_wr && avs_address == ADDR_DATA) begin
            next_stat.tx_full = 1'b1;
        end
        // A byte landing in the same cycle as the read keeps the flag set.
        if (take_rd && avs_address == ADDR_DATA &&
            !(state == ST_RECV && bit_end)) begin
            next_stat.rx_data_full_flag = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl <= CTRL_RESET;
            stat <= '0;
            rx_data <= '0;
            state <= ST_IDLE;
            phase <= '0;
            bitcnt <= '0;
            shreg <= '0;
            step <= STEP_FIRST;
            in_data <= 1'b0;
            div <= '0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            stat <= next_stat;
            rx_data <= next_rx_data;
            state <= next_state;
            phase <= next_phase;
            bitcnt <= next_bitcnt;
            shreg <= next_shreg;
            step <= next_step;
            in_data <= next_in_data;
            div <= next_div;
            scl_oe <= next_scl_oe;
            sda_oe <= next_sda_oe;
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end
    end

endmodule
